// ===== src/vic_arbiter.sv
// vectored interrupt controller: priority selection among candidate vectors
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module vic_arbiter #(
	parameter int N = 32
) (
	input wire logic [N-1:0] cand,
	input wire logic [N*vic_pkg::PRIO_W-1:0] prio,
	output logic win_valid,
	output logic [vic_pkg::VEC_W-1:0] win_vec,
	output logic [vic_pkg::PRIO_W-1:0] win_prio
);
	import vic_pkg::*;

	// scanning downward with <= lets the smaller vector take a tie
	always_comb begin
		win_valid = 1'b0;
		win_vec = '0;
		win_prio = '1;
		for (int i = N - 1; i >= 0; i--) begin
			if (cand[i] && prio[i*PRIO_W +: PRIO_W] <= win_prio) begin
				win_valid = 1'b1;
				win_vec = VEC_W'(i);
				win_prio = prio[i*PRIO_W +: PRIO_W];
			end
		end
	end

endmodule

// ===== src/vic_cpu.sv
// vectored interrupt controller: the cpu core end of the request link
// assumes the core supplies the return pc and a return-from-handler strobe
`timescale 1ns/1ps
module vic_cpu #(
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	vic_if.cpu bus,
	input wire logic [vic_pkg::ADDR_W-1:0] cur_pc,
	input wire logic return_from_handler_instr,
	output logic branch,
	output logic [vic_pkg::ADDR_W-1:0] branch_addr,
	output logic resume,
	output logic [vic_pkg::ADDR_W-1:0] resume_pc,
	output logic [vic_pkg::DEPTH_W-1:0] nest_depth
);
	import vic_pkg::*;

	typedef enum logic {
		VIC_CPU_RUN,
		VIC_CPU_ACK
	} vic_cpu_state_e;

	vic_cpu_state_e state;
	logic [CNT_W-1:0] cnt;
	logic [ADDR_W-1:0] pc_stack [DEPTH];
	logic cpu_ack_flag;
	logic isr_complete_flag;
	logic take_irq;
	logic do_branch;
	logic do_return;

	assign bus.cpu_ack_flag = cpu_ack_flag;
	assign bus.isr_complete_flag = isr_complete_flag;

	// a full stack refuses further nesting rather than overwrite a return pc
	assign take_irq = (state == VIC_CPU_RUN) && bus.irq_req && !cpu_ack_flag
		&& (nest_depth < DEPTH_W'(DEPTH));
	assign do_branch = (state == VIC_CPU_ACK) && (cnt == CNT_W'(ACK_HOLD - 1));
	assign do_return = (state == VIC_CPU_RUN) && !take_irq && return_from_handler_instr
		&& (nest_depth != '0);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= VIC_CPU_RUN;
			cnt <= '0;
			cpu_ack_flag <= 1'b0;
		end else begin
			unique case (state)
				VIC_CPU_RUN: begin
					if (take_irq) begin
						cpu_ack_flag <= 1'b1;
						cnt <= '0;
						state <= VIC_CPU_ACK;
					end
				end
				VIC_CPU_ACK: begin
					cnt <= cnt + CNT_W'(1);
					if (do_branch) begin
						cpu_ack_flag <= 1'b0;
						state <= VIC_CPU_RUN;
					end
				end
			endcase
		end
	end

	// handler address is read at the branch, in the last cycle of the acknowledge window
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			branch <= 1'b0;
			branch_addr <= ADDR_RST;
		end else begin
			branch <= do_branch;
			if (do_branch) begin
				branch_addr <= bus.isr_addr;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (do_branch) begin
			pc_stack[nest_depth[DEPTH_W-2:0]] <= cur_pc;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			nest_depth <= '0;
			resume <= 1'b0;
			resume_pc <= ADDR_RST;
			isr_complete_flag <= 1'b0;
		end else begin
			resume <= do_return;
			isr_complete_flag <= do_return;
			if (do_return) begin
				resume_pc <= pc_stack[3'(nest_depth - DEPTH_W'(1))];
				nest_depth <= nest_depth - DEPTH_W'(1);
			end else if (do_branch) begin
				nest_depth <= nest_depth + DEPTH_W'(1);
			end
		end
	end

endmodule

// ===== src/vic_ctrl.sv
// vectored interrupt controller: the controller end facing sources and software
// assumes sources and software strobes are synchronous to ref_clk
// configuration arrives on plain ports; the cpu core sits behind vic_if.cpu
`timescale 1ns/1ps
module vic_ctrl #(
	parameter int N = 32
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	vic_if.ctrl bus,
	input wire logic [N-1:0] fixed_irq,
	input wire logic [vic_pkg::DMA_GROUP-1:0] dma_term_out_low,
	input wire logic [vic_pkg::DMA_GROUP-1:0] dma_term_out_high,
	input wire logic [N-1:0] fabric_irq,
	input wire logic [N-1:0] vec_enable,
	input wire logic [N*vic_pkg::PRIO_W-1:0] vec_prio,
	input wire logic [N*vic_pkg::SRC_W-1:0] vec_src,
	input wire logic addr_we,
	input wire logic [vic_pkg::VEC_W-1:0] addr_vec,
	input wire logic [vic_pkg::ADDR_W-1:0] addr_data,
	input wire logic [N-1:0] sw_set,
	input wire logic [N-1:0] sw_clear,
	output logic [N-1:0] pending_flag,
	output logic [N-1:0] posted_flag,
	output logic [vic_pkg::NUM_PRIO-1:0] active_status
);
	import vic_pkg::*;

	logic [ADDR_W-1:0] handler_addr [N];
	logic [N-1:0] dma_lines;
	logic [N-1:0] src_line;
	logic [N-1:0] src_prev;
	logic [N-1:0] arrive;
	logic [N-1:0] ack_clear;
	logic [N-1:0] clr_posted_flag_d;
	logic [N-1:0] cand;
	logic ack_take;
	logic win_valid;
	logic [VEC_W-1:0] win_vec;
	logic [PRIO_W-1:0] win_prio;
	logic [PRIO_W-1:0] req_prio;
	logic [PRIO_W-1:0] top_level;
	logic active_any;
	logic preempt_ok;
	logic [NUM_PRIO-1:0] next_active;
	logic irq_req;
	logic [VEC_W-1:0] irq_vec;
	logic [ADDR_W-1:0] isr_addr;

	assign bus.irq_req = irq_req;
	assign bus.irq_vec = irq_vec;
	assign bus.isr_addr = isr_addr;

	// lowest set bit is the most urgent level now in service
	function automatic logic [PRIO_W-1:0] lowest_level(input logic [NUM_PRIO-1:0] lv);
		logic [PRIO_W-1:0] r;
		r = '0;
		for (int i = NUM_PRIO - 1; i >= 0; i--) begin
			if (lv[i]) begin
				r = PRIO_W'(i);
			end
		end
		return r;
	endfunction

	assign dma_lines = {dma_term_out_high, dma_term_out_low};

	// per-vector source selection; the fabric input is where any other line
	// is routed in, so a vector is not tied to its default fixed source
	for (genvar g = 0; g < N; g++) begin : g_src
		always_comb begin
			unique case (vic_src_e'(vec_src[g*SRC_W +: SRC_W]))
				VIC_SRC_FIXED: src_line[g] = fixed_irq[g];
				VIC_SRC_DMA: src_line[g] = dma_lines[g];
				VIC_SRC_FABRIC: src_line[g] = fabric_irq[g];
				VIC_SRC_NONE: src_line[g] = 1'b0;
			endcase
		end
	end

	// a rising edge marks arrival, so a held level raises one request only
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			src_prev <= '0;
		end else begin
			src_prev <= src_line;
		end
	end

	assign arrive = src_line & ~src_prev;

	assign ack_take = bus.cpu_ack_flag && irq_req;
	assign ack_clear = ack_take ? (32'h0000_0001 << irq_vec) : '0;

	// set beats clear: an arrival in the clearing cycle stays pending
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pending_flag <= '0;
		end else begin
			pending_flag <= (pending_flag & ~(ack_clear | sw_clear)) | arrive | sw_set;
		end
	end

	// posted clears one cycle behind pending on acknowledge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clr_posted_flag_d <= '0;
		end else begin
			clr_posted_flag_d <= ack_clear;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			posted_flag <= '0;
		end else begin
			posted_flag <= (posted_flag & ~(clr_posted_flag_d | sw_clear))
				| (pending_flag & vec_enable & ~sw_clear);
		end
	end

	// handler table, rewritable at any time
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				handler_addr[i] <= ADDR_RST;
			end
		end else if (addr_we) begin
			handler_addr[addr_vec] <= addr_data;
		end
	end

	assign cand = posted_flag & pending_flag & vec_enable;

	vic_arbiter #(
		.N(N)
	) u_arb (
		.cand(cand),
		.prio(vec_prio),
		.win_valid(win_valid),
		.win_vec(win_vec),
		.win_prio(win_prio)
	);

	assign top_level = lowest_level(active_status);
	assign active_any = |active_status;
	assign preempt_ok = !active_any || (win_prio < top_level);

	// a presented request is held until taken; it is withdrawn if software
	// cancels or disables its vector first, but not displaced by a newer one
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
			irq_vec <= '0;
			isr_addr <= ADDR_RST;
			req_prio <= '0;
		end else if (ack_take) begin
			irq_req <= 1'b0;
		end else if (irq_req && !cand[irq_vec]) begin
			irq_req <= 1'b0;
		end else if (!irq_req && !bus.cpu_ack_flag && win_valid && preempt_ok) begin
			irq_req <= 1'b1;
			irq_vec <= win_vec;
			isr_addr <= handler_addr[win_vec];
			req_prio <= win_prio;
		end
	end

	// active levels: acknowledge marks a level, completion drops the most
	// urgent one, which leaves the status as it was before that handler
	always_comb begin
		next_active = active_status;
		if (bus.isr_complete_flag && active_any) begin
			next_active[top_level] = 1'b0;
		end
		if (ack_take) begin
			next_active[req_prio] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			active_status <= ACTIVE_RST;
		end else begin
			active_status <= next_active;
		end
	end

endmodule

// ===== src/vic_if.sv
// vectored interrupt controller: link between the controller and the cpu core
// assumes both ends run on the same ref_clk; no clocking block
`timescale 1ns/1ps
interface vic_if;
	import vic_pkg::*;

	logic irq_req;
	logic [VEC_W-1:0] irq_vec;
	logic [ADDR_W-1:0] isr_addr;
	logic cpu_ack_flag;
	logic isr_complete_flag;

	modport ctrl (
		output irq_req,
		output irq_vec,
		output isr_addr,
		input cpu_ack_flag,
		input isr_complete_flag
	);

	modport cpu (
		input irq_req,
		input irq_vec,
		input isr_addr,
		output cpu_ack_flag,
		output isr_complete_flag
	);

endinterface

// ===== src/vic_pkg.sv
// vectored interrupt controller: shared constants and types
// assumes one 100 MHz clock (ref_clk) and a synchronous active-low reset
package vic_pkg;

	localparam int NUM_VEC = 32;
	localparam int VEC_W = 5;
	localparam int PRIO_W = 3;
	localparam int NUM_PRIO = 8;
	localparam int ADDR_W = 16;
	localparam int SRC_W = 2;
	localparam int DMA_GROUP = 16;
	localparam int STACK_DEPTH = 8;
	localparam int DEPTH_W = 4;

	// latency budget in cycles: pending, posted, request, acknowledge, branch
	localparam int PENDING_FLAG_CYC = 1;
	localparam int POSTED_FLAG_CYC = 1;
	localparam int IRQ_CYC = 1;
	localparam int IRA_CYC = 2;
	localparam int BRANCH_CYC = 7;
	localparam int TOTAL_CYC = PENDING_FLAG_CYC + POSTED_FLAG_CYC + IRQ_CYC + IRA_CYC + BRANCH_CYC;
	// acknowledge is raised one cycle after the request appears, so it stands one short
	localparam int ACK_HOLD = IRA_CYC + BRANCH_CYC - 1;
	localparam int CNT_W = 4;

	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [NUM_PRIO-1:0] ACTIVE_RST = 8'h00;

	typedef enum logic [SRC_W-1:0] {
		VIC_SRC_FIXED,
		VIC_SRC_DMA,
		VIC_SRC_FABRIC,
		VIC_SRC_NONE
	} vic_src_e;

endpackage

// ===== test/testbench.sv
// vic bench: both ends joined by vic_if; sources and core side driven here
// assumes ref_clk at 100 MHz, inputs changed at the falling edge
`timescale 1ns/1ps
module testbench;
	import vic_pkg::*;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [31:0] fixed_irq = '0, fabric_irq = '0, vec_enable = '0, sw_set = '0, sw_clear = '0;
	logic [15:0] dma_term_out_low = '0, dma_term_out_high = '0, addr_data = '0, cur_pc = '0;
	logic [95:0] vec_prio = '0;
	logic [63:0] vec_src = {32{2'h3}};
	logic addr_we = 1'h0;
	logic return_from_handler_instr = 1'h0;
	logic [4:0] addr_vec = '0;
	logic [31:0] pending_flag, posted_flag;
	logic [7:0] active_status;
	logic branch, resume;
	logic [15:0] branch_addr, resume_pc, pc1, pc2;
	logic [3:0] nest_depth;
	logic [15:0] tbl [32];
	logic [31:0] mask = '0;
	int fails = 0, n_tests = 0, cycles = 0, seed = 32'h7F79, v, u;
	always #5 ref_clk = ~ref_clk;
	vic_if vic_if_i ();
	vic_ctrl #(.N(32)) vic_ctrl_i (.ref_clk, .rst_n, .bus(vic_if_i.ctrl), .fixed_irq,
		.dma_term_out_low, .dma_term_out_high, .fabric_irq, .vec_enable, .vec_prio, .vec_src,
		.addr_we, .addr_vec, .addr_data, .sw_set, .sw_clear, .pending_flag, .posted_flag,
		.active_status);
	vic_cpu #(.DEPTH(8)) vic_cpu_i (.ref_clk, .rst_n, .bus(vic_if_i.cpu), .cur_pc,
		.return_from_handler_instr, .branch, .branch_addr, .resume, .resume_pc, .nest_depth);
	vic_assertions vic_assertions_i (.ref_clk, .rst_n, .irq_req(vic_if_i.irq_req),
		.irq_vec(vic_if_i.irq_vec), .isr_addr(vic_if_i.isr_addr),
		.cpu_ack_flag(vic_if_i.cpu_ack_flag), .isr_complete_flag(vic_if_i.isr_complete_flag));
	wire [1:0] link_st = {vic_if_i.cpu_ack_flag, vic_if_i.irq_req};
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ceiling well above the several hundred cycles the tests need
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// exact-cycle walk from arrival to branch; k 0 fixed, 1 dma, 2 fabric, 3 software
	task automatic arrive(int v, int k, output logic [15:0] pc);
		vec_src[2*v +: 2] = 2'(k);
		pc = 16'($random(seed));
		cur_pc = pc;
		case (k)
			0: fixed_irq[v] = 1'h1;
			1: if (v < 16) dma_term_out_low[v] = 1'h1; else dma_term_out_high[v-16] = 1'h1;
			2: fabric_irq[v] = 1'h1;
			default: sw_set[v] = 1'h1;
		endcase
		tick(1);
		{fixed_irq, fabric_irq, sw_set, dma_term_out_low, dma_term_out_high} = '0;
		chk("pending", 32'h1, 32'(pending_flag[v]));
		tick(1);
		chk("posted", 32'h1, 32'(posted_flag[v]));
		tick(1);
		chk("request", {11'h1, 5'(v), tbl[v]}, {vic_if_i.irq_req, vic_if_i.irq_vec, vic_if_i.isr_addr});
		tick(2);
		chk("ack", 32'h9, {link_st, pending_flag[v], posted_flag[v]});
		tick(1);
		chk("unposted", 32'h8, {link_st, pending_flag[v], posted_flag[v]});
		tick(6);
		chk("branch", {16'h1, tbl[v]}, {branch, branch_addr});
	endtask
	task automatic leave(logic [15:0] pc, logic [7:0] act);
		return_from_handler_instr = 1'h1;
		tick(1);
		return_from_handler_instr = 1'h0;
		chk("resume", {16'h3, pc}, {resume, vic_if_i.isr_complete_flag, resume_pc});
		tick(1);
		chk("active", 32'(act), 32'(active_status));
	endtask
	// expected winner: lowest level first, then lowest vector number
	function automatic int exp_win(logic [31:0] m);
		int w;
		w = -1;
		for (int i = 0; i < 32; i++) begin
			if (m[i] && (w < 0 || vec_prio[3*i +: 3] < vec_prio[3*w +: 3])) begin
				w = i;
			end
		end
		return w;
	endfunction
	// bounded wait for the next request, then follow it to the handler and back
	task automatic serve(inout logic [31:0] m);
		int t, w;
		w = exp_win(m);
		for (t = 0; t < 40 && vic_if_i.irq_req !== 1'h1; t++) tick(1);
		chk("winner", {27'h1, 5'(w)}, {vic_if_i.irq_req, vic_if_i.irq_vec});
		m[w] = 1'h0;
		tick(9);
		chk("branch", {16'h1, tbl[w]}, {branch, branch_addr});
		leave(cur_pc, 8'h00);
	endtask
	initial begin
		tick(20);
		rst_n = 1'h1;
		chk("reset", 32'h0, 32'(|{pending_flag, posted_flag, active_status, nest_depth}));
		vec_enable = '1;
		addr_we = 1'h1;
		for (v = 0; v < 32; v++) begin
			tbl[v] = 16'($random(seed));
			vec_prio[3*v +: 3] = 3'($random(seed));
			addr_vec = 5'(v);
			addr_data = tbl[v];
			tick(1);
		end
		addr_we = 1'h0;
		$display("test done: table load");
		// corners first: vector 0 on its fixed line, 31 and 15 at the dma group ends
		for (u = 0; u < 12; u++) begin
			v = (u < 2) ? 31 * u : (u == 5) ? 15 : {$random(seed)} % 32;
			arrive(v, u % 4, pc1);
			leave(pc1, 8'h00);
		end
		// a handler address rewritten at run time is used by the next request
		tbl[4] = 16'($random(seed));
		addr_vec = 5'h4;
		addr_data = tbl[4];
		addr_we = 1'h1;
		tick(1);
		addr_we = 1'h0;
		arrive(4, 2, pc1);
		leave(pc1, 8'h00);
		$display("test done: latency per source");
		vec_prio[9 +: 3] = 3'h6;
		vec_prio[27 +: 3] = 3'h6;
		vec_prio[60 +: 3] = 3'h4;
		mask = 32'h0010_0208;
		sw_set = mask;
		tick(1);
		sw_set = '0;
		serve(mask);
		serve(mask);
		serve(mask);
		$display("test done: priority order");
		vec_enable[7] = 1'h0;
		sw_set[7] = 1'h1;
		tick(1);
		sw_set = '0;
		tick(3);
		chk("disabled", 32'h4, {pending_flag[7], posted_flag[7], vic_if_i.irq_req});
		sw_clear[7] = 1'h1;
		tick(1);
		sw_clear = '0;
		chk("cleared", 32'h0, 32'(pending_flag[7]));
		vec_enable = '1;
		$display("test done: enable and clear");
		// random levels over random groups of vectors raised together
		for (u = 0; u < 6; u++) begin
			vec_prio = {$random(seed), $random(seed), $random(seed)};
			mask = $random(seed) & $random(seed) & $random(seed);
			mask[{$random(seed)} % 32] = 1'h1;
			sw_set = mask;
			tick(1);
			sw_set = '0;
			while (mask != '0) serve(mask);
		end
		$display("test done: random priority");
		vec_prio[36 +: 3] = 3'h5;
		vec_prio[75 +: 3] = 3'h2;
		arrive(12, 3, pc1);
		arrive(25, 3, pc2);
		chk("nest", {20'h2, 8'h24}, {nest_depth, active_status});
		leave(pc2, 8'h20);
		leave(pc1, 8'h00);
		$display("test done: nesting");
		finish_test();
	end
endmodule

// ===== test/vic_assertions.sv
// vic checker: request link timing between controller and core
// assumes one ref_clk domain; placed beside vic_if in the bench
`timescale 1ns/1ps
module vic_assertions (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic [vic_pkg::VEC_W-1:0] irq_vec,
	input wire logic [vic_pkg::ADDR_W-1:0] isr_addr,
	input wire logic cpu_ack_flag,
	input wire logic isr_complete_flag
);
	import vic_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_ACK_NEXT: assert property ($rose(irq_req) |=> cpu_ack_flag)
		else $error("ack not raised after request");
	AST_ACK_HOLD: assert property ($rose(cpu_ack_flag) |-> cpu_ack_flag[*8] ##1 !cpu_ack_flag)
		else $error("ack window length wrong");
	AST_REQ_DROP: assert property (irq_req && cpu_ack_flag |=> !irq_req)
		else $error("request kept after ack");
	AST_NO_REQ_IN_ACK: assert property ($rose(irq_req) |-> !cpu_ack_flag)
		else $error("request raised during ack");
	AST_ACK_CAUSE: assert property ($rose(cpu_ack_flag) |-> $past(irq_req))
		else $error("ack without request");
	AST_VEC_HOLD: assert property (irq_req && $past(irq_req) |-> $stable(irq_vec))
		else $error("vector number moved");
	AST_ADDR_HOLD: assert property (!$rose(irq_req) |-> $stable(isr_addr))
		else $error("handler address moved");
	AST_DONE_PULSE: assert property (isr_complete_flag |=> !isr_complete_flag)
		else $error("completion longer than one cycle");
	COV_REQ: cover property ($rose(irq_req));
	COV_DONE: cover property (isr_complete_flag);
	COV_NEXT: cover property ($fell(cpu_ack_flag) ##[1:8] $rose(irq_req));
endmodule
